// >>> dasa_pkg.sv
// package of constants and carrier types for the dual converter status aggregator
// ****************************************************************
// Operation
// - status word 0 bits 31:24 mirror group-B slot overwrite flags live
// - status word 0 bits 23:16 mirror group-A slot overwrite flags live
// - status word 0 bits 15:8 mirror group-B slot fresh-data flags live
// - status word 0 bits 7:0 mirror group-A slot fresh-data flags live
// - any_slot_overwrite is OR of every slot overwrite flag
// - any_slot_fresh is OR of every slot fresh-data flag
// - any_trigger_overrun is OR of sixteen trigger overrun flags
// - any_irq_flag_overwrite is OR of four interrupt flag overwrite indicators
// - converter B input field: current input while active, last input while idle
// - converter A input field: current input while active, last input while idle
// - conv_b_active reads 1 while converter B converts
// - conv_a_active reads 1 while converter A converts
// - compare1 match flag sets on condition met, write one clears
// - compare0 match flag sets on condition met, write one clears
// - match flag sets once match counter reaches limit plus one
// - compare level is 0 below compare value, 1 at or above
// - four conversion-done flags set on irq pulse, write one clears
// ****************************************************************
package dasa_pkg;

  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFF_FLAG_MIRROR = 8'hb0;
  localparam logic [7:0]  OFF_SUMMARY     = 8'hb4;
  localparam logic [31:0] RESET_WORD      = 32'h0000_0000;

  // summary register field positions
  localparam int POS_ANY_OVW   = 27;
  localparam int POS_ANY_FRESH = 26;
  localparam int POS_ANY_TRIG  = 25;
  localparam int POS_ANY_IRQOV = 24;
  localparam int POS_CH_B      = 20;
  localparam int POS_ACT_B     = 16;
  localparam int POS_CH_A      = 12;
  localparam int POS_ACT_A     = 8;
  localparam int POS_CMP_FLAG  = 6;
  localparam int POS_CMP_LVL   = 4;
  localparam int POS_DONE      = 0;

  localparam int NUM_CMP   = 2;
  localparam int NUM_DONE  = 4;
  localparam int NUM_SLOT  = 8;
  localparam int NUM_TRIG  = 16;
  localparam int CNT_W     = 5;

  typedef struct packed {
    logic [NUM_SLOT-1:0] ovw_b;
    logic [NUM_SLOT-1:0] ovw_a;
    logic [NUM_SLOT-1:0] fresh_b;
    logic [NUM_SLOT-1:0] fresh_a;
  } dasa_slot_flags_s;

  typedef struct packed {
    logic        active;
    logic [2:0]  input_select;
  } dasa_conv_s;

  typedef struct packed {
    logic        enable;
    logic        cond_ge;
    logic [3:0]  match_count_limit;
    logic [11:0] compare_value;
    logic [2:0]  slot_select;
  } dasa_cmp_cfg_s;

  typedef struct packed {
    logic        load;
    logic [2:0]  slot;
    logic [11:0] data;
  } dasa_result_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } dasa_bus_s;

endpackage : dasa_pkg

// >>> dasa_status.sv
// status register bank of the dual converter controller
`timescale 1ns/100ps
module dasa_status
  import dasa_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire dasa_bus_s                   bus,
  output logic [31:0]                      rdata,
  input  wire dasa_slot_flags_s            slot_flags,
  input  wire logic [NUM_TRIG-1:0]         trigger_overrun_flag,
  input  wire logic [NUM_DONE-1:0]         irq_flag_overwrite,
  input  wire dasa_conv_s                  converter_a,
  input  wire dasa_conv_s                  converter_b,
  input  wire dasa_cmp_cfg_s [NUM_CMP-1:0] cmp_cfg,
  input  wire dasa_result_s                result,
  input  wire logic [NUM_DONE-1:0]         conversion_done_irq,
  output logic [NUM_CMP-1:0]               compare_match_flag,
  output logic [NUM_CMP-1:0]               compare_level,
  output logic [NUM_DONE-1:0]              conv_done_flag
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [31:0]                    rdata;
    logic [2:0]                     last_a;
    logic [2:0]                     last_b;
    logic [NUM_CMP-1:0]             cmp_flag;
    logic [NUM_CMP-1:0]             cmp_level;
    logic [NUM_CMP-1:0][CNT_W-1:0]  cmp_cnt;
    logic [NUM_DONE-1:0]            done;
  } dasa_state_s;

  dasa_state_s state;
  dasa_state_s next_state;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic cmp_hit(input dasa_cmp_cfg_s cfg, input logic [11:0] data);
    logic ge;
    ge = (data >= cfg.compare_value);
    return cfg.cond_ge ? ge : !ge;
  endfunction : cmp_hit

  function automatic logic [2:0] shown_input(input dasa_conv_s conv, input logic [2:0] last);
    return conv.active ? conv.input_select : last;
  endfunction : shown_input

  // ****************************************************************
  // register images
  // ****************************************************************
  logic [31:0] mirror_word;
  logic [31:0] summary_word;
  logic        sum_wr;

  always_comb begin
    mirror_word = {slot_flags.ovw_b,
                   slot_flags.ovw_a,
                   slot_flags.fresh_b,
                   slot_flags.fresh_a};
  end

  always_comb begin
    summary_word = RESET_WORD;
    summary_word[POS_ANY_OVW]   = |{slot_flags.ovw_a, slot_flags.ovw_b};
    summary_word[POS_ANY_FRESH] = |{slot_flags.fresh_a, slot_flags.fresh_b};
    summary_word[POS_ANY_TRIG]  = |trigger_overrun_flag;
    summary_word[POS_ANY_IRQOV] = |irq_flag_overwrite;
    summary_word[POS_CH_B +: 3] = shown_input(converter_b, state.last_b);
    summary_word[POS_ACT_B]     = converter_b.active;
    summary_word[POS_CH_A +: 3] = shown_input(converter_a, state.last_a);
    summary_word[POS_ACT_A]     = converter_a.active;
    summary_word[POS_CMP_FLAG +: NUM_CMP] = state.cmp_flag;
    summary_word[POS_CMP_LVL +: NUM_CMP]  = state.cmp_level;
    summary_word[POS_DONE +: NUM_DONE]    = state.done;
  end

  // only the summary register has writable bits; the mirror ignores writes
  assign sum_wr = bus.wr && (bus.addr == OFF_SUMMARY);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic hit;
    logic reach;
    logic [CNT_W-1:0] limit;
    hit   = 1'b0;
    reach = 1'b0;
    limit = '0;
    next_state = state;

    // read data stands only in the cycle after the strobe
    next_state.rdata = RESET_WORD;
    if (bus.rd) begin
      if (bus.addr == OFF_FLAG_MIRROR) begin
        next_state.rdata = mirror_word;
      end else if (bus.addr == OFF_SUMMARY) begin
        next_state.rdata = summary_word;
      end
    end

    // remember the input while busy so idle shows the last one
    if (converter_a.active) begin
      next_state.last_a = converter_a.input_select;
    end
    if (converter_b.active) begin
      next_state.last_b = converter_b.input_select;
    end

    // write one clears first, so a same-cycle event below wins
    if (sum_wr) begin
      next_state.cmp_flag = state.cmp_flag & ~bus.wdata[POS_CMP_FLAG +: NUM_CMP];
      next_state.done     = state.done & ~bus.wdata[POS_DONE +: NUM_DONE];
    end

    next_state.done = next_state.done | conversion_done_irq;

    for (int i = 0; i < NUM_CMP; i++) begin
      if (result.load && cmp_cfg[i].enable && (result.slot == cmp_cfg[i].slot_select)) begin
        // level tracks the latest selected result against the threshold
        next_state.cmp_level[i] = (result.data >= cmp_cfg[i].compare_value);
        hit   = cmp_hit(cmp_cfg[i], result.data);
        limit = {1'b0, cmp_cfg[i].match_count_limit} + 5'h01;
        if (hit) begin
          reach = ((state.cmp_cnt[i] + 5'h01) >= limit);
          if (reach) begin
            next_state.cmp_flag[i] = 1'b1;
            next_state.cmp_cnt[i]  = '0;
          end else begin
            next_state.cmp_cnt[i] = state.cmp_cnt[i] + 5'h01;
          end
        end else begin
          // a miss breaks the run of matches
          next_state.cmp_cnt[i] = '0;
        end
      end else if (!cmp_cfg[i].enable) begin
        next_state.cmp_cnt[i] = '0;
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rdata              = state.rdata;
  assign compare_match_flag = state.cmp_flag;
  assign compare_level      = state.cmp_level;
  assign conv_done_flag     = state.done;

endmodule : dasa_status

// >>> dasa_status_sva.sv
// port-level checker of the status bank
`timescale 1ns/100ps
module dasa_status_sva
  import dasa_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        rst,
  input wire dasa_bus_s                   bus,
  input wire logic [31:0]                 rdata,
  input wire dasa_slot_flags_s            slot_flags,
  input wire logic [NUM_TRIG-1:0]         trigger_overrun_flag,
  input wire logic [NUM_DONE-1:0]         irq_flag_overwrite,
  input wire dasa_conv_s                  converter_a,
  input wire dasa_conv_s                  converter_b,
  input wire dasa_cmp_cfg_s [NUM_CMP-1:0] cmp_cfg,
  input wire dasa_result_s                result,
  input wire logic [NUM_DONE-1:0]         conversion_done_irq,
  input wire logic [NUM_CMP-1:0]          compare_match_flag,
  input wire logic [NUM_CMP-1:0]          compare_level,
  input wire logic [NUM_DONE-1:0]         conv_done_flag
);
  // ****
  // properties
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic rd0, rd1, wr1;
  assign rd0 = bus.rd && bus.addr == OFF_FLAG_MIRROR;
  assign rd1 = bus.rd && bus.addr == OFF_SUMMARY;
  assign wr1 = bus.wr && bus.addr == OFF_SUMMARY;
  property p_or;
    dasa_slot_flags_s s; logic [19:0] t;
    (rd1, s = slot_flags, t = {trigger_overrun_flag, irq_flag_overwrite}) |=>
      rdata[27:24] == {|{s.ovw_b, s.ovw_a}, |{s.fresh_b, s.fresh_a}, |t[19:4], |t[3:0]};
  endproperty
  property p_cv;
    dasa_conv_s a, b;
    (rd1, a = converter_a, b = converter_b) |=> rdata[16] == b.active && rdata[8] == a.active &&
      (!a.active || rdata[14:12] == a.input_select) && (!b.active || rdata[22:20] == b.input_select);
  endproperty
  property p_lvl;
    logic [11:0] d, v;
    (result.load && cmp_cfg[0].enable && result.slot == cmp_cfg[0].slot_select,
     d = result.data, v = cmp_cfg[0].compare_value) |=> compare_level[0] == (d >= v);
  endproperty
  a_mirror_read: assert property (rd0 |=> rdata == $past(slot_flags))
    else $error("mirror read wrong");
  a_summary_or: assert property (p_or) else $error("summary or wrong");
  a_conv_fields: assert property (p_cv) else $error("converter fields wrong");
  a_reserved_zero: assert property (rd1 |=> {rdata[31:28], rdata[23], rdata[19:17], rdata[15], rdata[11:9]} == 12'h0)
    else $error("reserved bits set");
  a_flag_read: assert property (rd1 |=> rdata[7:0] == {$past(compare_match_flag), $past(compare_level), $past(conv_done_flag)})
    else $error("flag byte wrong");
  a_done_set: assert property (|conversion_done_irq |=> (conv_done_flag & $past(conversion_done_irq)) == $past(conversion_done_irq))
    else $error("done flag not set");
  a_zero_keep: assert property (wr1 && bus.wdata[3:0] == 4'h0 && conversion_done_irq == 4'h0 |=> $stable(conv_done_flag))
    else $error("zero write changed flags");
  a_cmp_clear: assert property (wr1 && bus.wdata[7:6] == 2'b11 && !result.load |=> compare_match_flag == 2'b00)
    else $error("match flags not cleared");
  a_level_update: assert property (p_lvl) else $error("compare level wrong");
  a_rdata_idle: assert property (!bus.rd |=> rdata == 32'h0)
    else $error("read data outside read cycle");
  c_mirror: cover property (rd0);
  c_done_clear: cover property (|conv_done_flag ##1 wr1);
  c_match: cover property (compare_match_flag[0]);
endmodule : dasa_status_sva

// >>> dasa_status_tb.sv
// self-checking bench of the status bank
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; $display("CHECK FAILED %0t got %h expected %h", $time, a, e); end end
module dasa_status_tb;
  import dasa_pkg::*;
  logic clk, rst;
  logic [31:0] rdata;
  logic [15:0] tov;
  logic [3:0] iov, irq, cdf;
  logic [1:0] cmf, cml;
  dasa_bus_s bus;
  dasa_slot_flags_s sf;
  dasa_conv_s ca, cb;
  dasa_cmp_cfg_s [1:0] cfg;
  dasa_result_s res;
  int fails, n_tests;
  dasa_status DUT (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .slot_flags(sf), .trigger_overrun_flag(tov),
    .irq_flag_overwrite(iov), .converter_a(ca), .converter_b(cb), .cmp_cfg(cfg), .result(res),
    .conversion_done_irq(irq), .compare_match_flag(cmf), .compare_level(cml), .conv_done_flag(cdf));
  // ****
  // bus and stimulus tasks
  // ****
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask : rd
  task automatic ld(input logic [2:0] s, input logic [11:0] d);
    @(posedge clk);
    res <= '{1'b1, s, d};
    @(posedge clk);
    res.load <= 1'b0;
  endtask : ld
  task automatic final_report;
    if (fails == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // a hang counts as a failure
  initial begin
    repeat (2000) @(posedge clk);
    fails++;
    final_report;
  end
  initial begin
    {rst, bus, sf, tov, iov, irq, ca, cb, res, fails, n_tests} = '0;
    rst = 1'b1;
    cfg[0] = '{1'b1, 1'b1, 4'h1, 12'h800, 3'h3};
    cfg[1] = '{1'b1, 1'b0, 4'h0, 12'h100, 3'h5};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_FLAG_MIRROR, 32'h0);
    rd(OFF_SUMMARY, 32'h0);
    rd(8'hb8, 32'h0);
    @(posedge clk);
    irq <= 4'hf;
    @(posedge clk);
    irq <= 4'h0;
    wr(OFF_SUMMARY, 32'hffff_fff0);
    wr(OFF_FLAG_MIRROR, 32'hffff_ffff);
    rd(OFF_SUMMARY, 32'h0000_000f);
    wr(OFF_SUMMARY, 32'h0000_0005);
    #1 `CHK(cdf, 4'ha)
    // limit 1 needs two hits in a row before the flag rises
    ld(3'h3, 12'h900);
    #1 `CHK({cmf, cml}, 4'b0001)
    ld(3'h3, 12'h900);
    #1 `CHK({cmf, cml}, 4'b0101)
    ld(3'h5, 12'h050);
    #1 `CHK({cmf, cml}, 4'b1101)
    rd(OFF_SUMMARY, 32'h0000_00da);
    wr(OFF_SUMMARY, 32'h0000_0040);
    #1 `CHK(cmf, 2'b10)
    wr(OFF_SUMMARY, 32'h0000_008a);
    #1 `CHK({cmf, cdf}, 6'h0)
    ld(3'h3, 12'h7ff);
    #1 `CHK(cml, 2'b00)
    @(posedge clk);
    ca <= '{1'b1, 3'h5};
    cb <= '{1'b1, 3'h2};
    rd(OFF_SUMMARY, 32'h0021_5100);
    @(posedge clk);
    ca <= '{1'b0, 3'h0};
    cb <= '{1'b0, 3'h7};
    rd(OFF_SUMMARY, 32'h0020_5000);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      sf <= 32'h81 << (8 * i);
      rd(OFF_FLAG_MIRROR, 32'h81 << (8 * i));
      rd(OFF_SUMMARY, 32'h0020_5000 | (i > 1 ? 32'h0800_0000 : 32'h0400_0000));
    end
    @(posedge clk);
    sf <= '0;
    tov <= 16'h8000;
    rd(OFF_SUMMARY, 32'h0220_5000);
    @(posedge clk);
    tov <= 16'h0;
    iov <= 4'h8;
    rd(OFF_SUMMARY, 32'h0120_5000);
    final_report;
  end
endmodule : dasa_status_tb
bind dasa_status dasa_status_sva u_sva (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .slot_flags(slot_flags),
  .trigger_overrun_flag(trigger_overrun_flag), .irq_flag_overwrite(irq_flag_overwrite), .converter_a(converter_a),
  .converter_b(converter_b), .cmp_cfg(cmp_cfg), .result(result), .conversion_done_irq(conversion_done_irq),
  .compare_match_flag(compare_match_flag), .compare_level(compare_level), .conv_done_flag(conv_done_flag));
